// file: logic/i2crs_pkg.sv
// i2crs_pkg: shared constants for the two-wire register slave and its master
// assumes: both ends and the joining interface compile after this package
package i2crs_pkg;
    // ****************************************************************
    // bus addressing
    // ****************************************************************
    localparam logic [6:0] TARGET_ADDR    = 7'h61;      // fixed bus address
    localparam logic [2:0] BIT_COUNT_LAST = 3'h7;       // eight bits a byte
    // ****************************************************************
    // register indices
    // ****************************************************************
    localparam logic [7:0] IDX_DEV_REVISION = 8'h00;
    localparam logic [7:0] IDX_FUSE_VERSION = 8'h01;
    localparam logic [7:0] IDX_CONV0_CTRL   = 8'h02;
    localparam logic [7:0] IDX_CONV0_LIMSL  = 8'h03;
    localparam logic [7:0] IDX_CONV1_CTRL   = 8'h04;
    localparam logic [7:0] IDX_CONV1_LIMSL  = 8'h05;
    localparam logic [7:0] IDX_CONV0_VSET   = 8'h06;
    localparam logic [7:0] IDX_CONV1_VSET   = 8'h07;
    localparam logic [7:0] IDX_CONV0_DELAY  = 8'h0C;
    localparam logic [7:0] IDX_CONV1_DELAY  = 8'h0D;
    // ****************************************************************
    // writable masks and fixed reserved values
    // ****************************************************************
    localparam logic [7:0] CTRL_WMASK     = 8'h0F;      // bits 3:0 live
    localparam logic [7:0] LIMSL_WMASK    = 8'h3F;      // bits 5:0 live
    localparam logic [7:0] FULL_WMASK     = 8'hFF;
    localparam logic [5:0] REV_RSVD_VALUE = 6'h02;      // reserved 00 0010
    localparam logic [7:0] RST_ZERO       = 8'h00;
    // ****************************************************************
    // master command port offsets (controller registers)
    // ****************************************************************
    localparam logic [1:0] CMD_OFS_CTRL   = 2'h0;       // go/kind
    localparam logic [1:0] CMD_OFS_INDEX  = 2'h1;       // register index
    localparam logic [1:0] CMD_OFS_DATA   = 2'h2;       // write data / read
    localparam logic [1:0] CMD_OFS_STATUS = 2'h3;       // busy, nak
    localparam logic [7:0] HALF_PERIOD    = 8'h0A;      // tick every 11 ref cycles, a quarter of a bit
endpackage

// file: logic/i2crs_if.sv
// i2crs_if: the two open-drain wires shared by both ends
// assumes: each end drives low only through its enable; pull-ups make high
`timescale 1ns/1ns
`default_nettype none
interface i2crs_if;
    logic scl_oe_m;     // master pulls clock low
    logic sda_oe_m;     // master pulls data low
    logic sda_oe_s;     // slave pulls data low
    logic scl;          // resolved clock level
    logic sda;          // resolved data level
    // wired-and of open-drain pulls with pull-up
    assign scl = ~scl_oe_m;
    assign sda = ~(sda_oe_m | sda_oe_s);
    modport master (output scl_oe_m, output sda_oe_m, input scl, input sda);
    modport slave  (output sda_oe_s, input scl, input sda);
endinterface
`default_nettype wire

// file: logic/i2crs_sync.sv
// i2crs_sync: two flip-flop synchroniser for the bus lines
// assumes: input is asynchronous to clk; idle level is high
`timescale 1ns/1ns
`default_nettype none
module i2crs_sync (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic d_in,
    output logic      q_out
);
    logic meta_reg;     // first stage, read only by the second
    // ****************************************************************
    // two stages, reset to the idle-high bus level
    // ****************************************************************
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_reg <= 1'b1;
            q_out    <= 1'b1;
        end else begin
            meta_reg <= d_in;
            q_out    <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// file: logic/i2crs_slave.sv
// i2crs_slave: register slave end of the two-wire link
// assumes: REF_CLK_IN far faster than scl; fuse values steady at load
`timescale 1ns/1ns
`default_nettype none
module i2crs_slave #(
    parameter logic [7:0] FUSE_DEFAULT = 8'h00   // arbitrary fuse fallback
) (
    input  wire logic       REF_CLK_IN,
    input  wire logic       RST_N_IN,
    i2crs_if.slave          bus,
    input  wire logic       SUPPLY_OK_IN,         // supply above threshold
    input  wire logic       FUSE_LOAD_IN,         // fuse copy strobe level
    input  wire logic [1:0] FUSE_PART_ID_IN,      // part_identity_field
    input  wire logic [7:0] FUSE_VERSION_IN,      // fuse_version_field
    input  wire logic [7:0] FUSE_CONV0_CTRL_IN,
    input  wire logic [7:0] FUSE_CONV1_CTRL_IN,
    input  wire logic [7:0] FUSE_CONV0_VSET_IN,
    input  wire logic [7:0] FUSE_CONV1_VSET_IN,
    output logic            BUS_BUSY_OUT,         // session open
    output logic            CONV_ENABLE_OUT,      // converters may run
    output logic [7:0]      CONV0_CTRL_OUT,
    output logic [7:0]      CONV1_CTRL_OUT,
    output logic [7:0]      CONV0_VSET_OUT,
    output logic [7:0]      CONV1_VSET_OUT
);
    typedef enum {ST_IDLE, ST_ADDR, ST_INDEX, ST_WDATA, ST_RDATA,
                  ST_IGNORE} i2crs_state_t;
    // ****************************************************************
    // synchronised lines and edge detection
    // ****************************************************************
    logic scl_s, sda_s;                    // synchronised levels
    logic scl_d_reg, sda_d_reg;            // one cycle older
    i2crs_sync u_scl (.clk_in(REF_CLK_IN), .rst_n_in(RST_N_IN),
                      .d_in(bus.scl), .q_out(scl_s));
    i2crs_sync u_sda (.clk_in(REF_CLK_IN), .rst_n_in(RST_N_IN),
                      .d_in(bus.sda), .q_out(sda_s));
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end
    logic scl_rise, scl_fall, start_det, stop_det;
    assign scl_rise  = scl_s & ~scl_d_reg;
    assign scl_fall  = ~scl_s & scl_d_reg;
    assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
    // ****************************************************************
    // register file
    // ****************************************************************
    logic [1:0] part_id_reg;               // identity, fuse loaded
    logic [7:0] fuse_ver_reg;
    logic [7:0] regs_reg [2:7];            // converter control set
    logic [7:0] delay0_reg, delay1_reg;    // sequencing delays
    logic       fuse_done_reg;             // fuse copy finished
    logic       wr_pulse;                  // byte to store
    logic [7:0] idx_reg, shift_reg;        // index and shifter
    // writable bits per index; reserved and read-only give zero
    function automatic logic [7:0] wmask(input logic [7:0] idx);
        case (idx)
            i2crs_pkg::IDX_CONV0_CTRL,
            i2crs_pkg::IDX_CONV1_CTRL:  wmask = i2crs_pkg::CTRL_WMASK;
            i2crs_pkg::IDX_CONV0_LIMSL,
            i2crs_pkg::IDX_CONV1_LIMSL: wmask = i2crs_pkg::LIMSL_WMASK;
            i2crs_pkg::IDX_CONV0_VSET, i2crs_pkg::IDX_CONV1_VSET,
            i2crs_pkg::IDX_CONV0_DELAY,
            i2crs_pkg::IDX_CONV1_DELAY: wmask = i2crs_pkg::FULL_WMASK;
            default:                    wmask = i2crs_pkg::RST_ZERO;
        endcase
    endfunction
    // fuse copy while the load level is high, then writes by the host
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            part_id_reg   <= 2'h0;
            fuse_ver_reg  <= FUSE_DEFAULT;
            for (int i = 2; i < 8; i++) begin
                regs_reg[i] <= i2crs_pkg::RST_ZERO;
            end
            delay0_reg    <= i2crs_pkg::RST_ZERO;
            delay1_reg    <= i2crs_pkg::RST_ZERO;
            fuse_done_reg <= 1'b0;
        end else if (FUSE_LOAD_IN) begin
            // fuse values taken after reset release
            part_id_reg   <= FUSE_PART_ID_IN;
            fuse_ver_reg  <= FUSE_VERSION_IN;
            regs_reg[2]   <= FUSE_CONV0_CTRL_IN & i2crs_pkg::CTRL_WMASK;
            regs_reg[4]   <= FUSE_CONV1_CTRL_IN & i2crs_pkg::CTRL_WMASK;
            regs_reg[6]   <= FUSE_CONV0_VSET_IN;
            regs_reg[7]   <= FUSE_CONV1_VSET_IN;
            fuse_done_reg <= 1'b1;
        end else if (wr_pulse) begin
            // masked store
            if (idx_reg >= i2crs_pkg::IDX_CONV0_CTRL &&
                idx_reg <= i2crs_pkg::IDX_CONV1_VSET) begin
                regs_reg[idx_reg[2:0]] <= shift_reg & wmask(idx_reg);
            end else if (idx_reg == i2crs_pkg::IDX_CONV0_DELAY) begin
                delay0_reg <= shift_reg;
            end else if (idx_reg == i2crs_pkg::IDX_CONV1_DELAY) begin
                delay1_reg <= shift_reg;
            end
        end
    end
    // byte-wide read view of every register
    function automatic logic [7:0] rd_view(input logic [7:0] idx);
        case (idx)
            i2crs_pkg::IDX_DEV_REVISION:
                rd_view = {part_id_reg, i2crs_pkg::REV_RSVD_VALUE};
            i2crs_pkg::IDX_FUSE_VERSION: rd_view = fuse_ver_reg;
            i2crs_pkg::IDX_CONV0_DELAY:  rd_view = delay0_reg;
            i2crs_pkg::IDX_CONV1_DELAY:  rd_view = delay1_reg;
            default: begin
                if (idx >= i2crs_pkg::IDX_CONV0_CTRL &&
                    idx <= i2crs_pkg::IDX_CONV1_VSET) begin
                    rd_view = regs_reg[idx[2:0]];
                end else begin
                    rd_view = i2crs_pkg::RST_ZERO;
                end
            end
        endcase
    endfunction
    logic [7:0] rd_byte;                   // byte to serve on a read
    assign rd_byte = rd_view(idx_reg);
    // ****************************************************************
    // protocol engine
    // ****************************************************************
    i2crs_state_t state_reg;
    logic [2:0]   bit_reg;                 // bit within byte
    logic         ack_phase_reg;           // in ninth pulse slot
    logic         drive_reg;               // want sda low
    logic         master_nak_reg;          // nak seen on read
    logic         last_bit;
    assign last_bit = (bit_reg == i2crs_pkg::BIT_COUNT_LAST);
    assign wr_pulse = scl_fall & ~ack_phase_reg & last_bit &
                      (state_reg == ST_WDATA);
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state_reg      <= ST_IDLE;
            bit_reg        <= 3'h0;
            ack_phase_reg  <= 1'b0;
            drive_reg      <= 1'b0;
            shift_reg      <= 8'h00;
            idx_reg        <= 8'h00;
            master_nak_reg <= 1'b0;
        end else if (start_det) begin
            // repeated start handled the same
            state_reg     <= ST_ADDR;
            bit_reg       <= 3'h0;
            // the clock fall that closes the start must not count a bit
            ack_phase_reg <= 1'b1;
            drive_reg     <= 1'b0;
        end else if (stop_det) begin
            state_reg <= ST_IDLE;
            drive_reg <= 1'b0;
        end else if (scl_rise && !ack_phase_reg) begin
            // sample msb first
            shift_reg <= {shift_reg[6:0], sda_s};
        end else if (scl_rise && ack_phase_reg && state_reg == ST_RDATA) begin
            master_nak_reg <= sda_s;
        end else if (scl_fall) begin
            // every change made just after scl falls
            if (!ack_phase_reg) begin
                bit_reg <= bit_reg + 3'h1;
                if (state_reg == ST_RDATA) begin
                    drive_reg <= ~shift_reg[7] & ~last_bit;
                end
                if (last_bit) begin
                    ack_phase_reg <= 1'b1;
                    case (state_reg)
                        ST_ADDR: begin
                            if (shift_reg[7:1] == i2crs_pkg::TARGET_ADDR) begin
                                drive_reg <= 1'b1;
                                state_reg <= shift_reg[0] ? ST_RDATA
                                                          : ST_INDEX;
                            end else begin
                                state_reg <= ST_IGNORE;
                            end
                        end
                        ST_INDEX: begin
                            idx_reg   <= shift_reg;
                            drive_reg <= 1'b1;
                            state_reg <= ST_WDATA;
                        end
                        ST_WDATA: begin
                            idx_reg   <= idx_reg + 8'h01;
                            drive_reg <= 1'b1;
                        end
                        default: drive_reg <= 1'b0;
                    endcase
                end
            end else begin
                // leaving the ack slot
                ack_phase_reg <= 1'b0;
                drive_reg     <= 1'b0;
                if (state_reg == ST_RDATA) begin
                    // index left alone on reads
                    shift_reg <= rd_byte;
                    drive_reg <= ~rd_byte[7];
                    if (master_nak_reg) begin
                        state_reg <= ST_IGNORE;
                        drive_reg <= 1'b0;
                    end
                end
            end
        end
    end
    // ****************************************************************
    // outputs
    // ****************************************************************
    // released under low supply whatever the engine wants
    assign bus.sda_oe_s    = drive_reg & SUPPLY_OK_IN;
    assign BUS_BUSY_OUT    = (state_reg != ST_IDLE);
    assign CONV_ENABLE_OUT = fuse_done_reg & ~FUSE_LOAD_IN;
    assign CONV0_CTRL_OUT  = regs_reg[2];
    assign CONV1_CTRL_OUT  = regs_reg[4];
    assign CONV0_VSET_OUT  = regs_reg[6];
    assign CONV1_VSET_OUT  = regs_reg[7];
endmodule
`default_nettype wire

// file: logic/i2crs_master.sv
// i2crs_master: host end, one register write or read per command
// assumes: software uses the plain strobe port; scl made by divider
`timescale 1ns/1ns
`default_nettype none
module i2crs_master (
    input  wire logic       REF_CLK_IN,
    input  wire logic       RST_N_IN,
    i2crs_if.master         bus,
    input  wire logic [1:0] ADDR_IN,
    input  wire logic [7:0] WDATA_IN,
    input  wire logic       WR_IN,
    input  wire logic       RD_IN,
    output logic [7:0]      RDATA_OUT
);
    typedef enum {MS_IDLE, MS_START, MS_BIT, MS_STOP} i2crs_mstate_t;
    // ****************************************************************
    // command registers
    // ****************************************************************
    logic [7:0] index_reg, data_reg;       // target index, data byte
    logic       kind_reg;                  // 1 = read
    logic       go;                        // command accepted
    logic       busy_reg, nak_reg;
    assign go = WR_IN && ADDR_IN == i2crs_pkg::CMD_OFS_CTRL && WDATA_IN[0]
                && !busy_reg;
    // ****************************************************************
    // bit sequencer: frames are a list of bytes
    // ****************************************************************
    i2crs_mstate_t st_reg;
    logic [7:0] div_reg;                   // quarter-bit tick divider
    logic [1:0] phase_reg;                 // quarter of a bit
    logic [3:0] bit_reg;                   // 0..8, 8 = ack slot
    logic [2:0] byte_reg;                  // byte within command
    logic [7:0] sh_reg;
    logic       scl_low_reg, sda_low_reg;
    logic       tick;
    // divider sets the bus rate
    assign tick = (div_reg == i2crs_pkg::HALF_PERIOD);
    // byte to send: write = addr,idx,data; read = addr,idx,restart,addr|1
    function automatic logic [7:0] frame_byte(input logic [2:0] n);
        case (n)
            3'h0:    frame_byte = {i2crs_pkg::TARGET_ADDR, 1'b0};
            3'h1:    frame_byte = index_reg;
            3'h2:    frame_byte = kind_reg ? {i2crs_pkg::TARGET_ADDR, 1'b1}
                                           : data_reg;
            default: frame_byte = 8'hFF;   // released: slave drives
        endcase
    endfunction
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            st_reg <= MS_IDLE;  div_reg <= 8'h00;  phase_reg <= 2'h0;
            bit_reg <= 4'h0;  byte_reg <= 3'h0;  sh_reg <= 8'h00;
            scl_low_reg <= 1'b0;  sda_low_reg <= 1'b0;
            busy_reg <= 1'b0;  nak_reg <= 1'b0;  RDATA_OUT <= 8'h00;
            index_reg <= 8'h00;  data_reg <= 8'h00;  kind_reg <= 1'b0;
        end else begin
            div_reg <= tick ? 8'h00 : div_reg + 8'h01;
            if (WR_IN && ADDR_IN == i2crs_pkg::CMD_OFS_INDEX) index_reg <= WDATA_IN;
            if (WR_IN && ADDR_IN == i2crs_pkg::CMD_OFS_DATA) data_reg <= WDATA_IN;
            if (RD_IN) begin
                RDATA_OUT <= (ADDR_IN == i2crs_pkg::CMD_OFS_DATA) ? sh_reg
                           : (ADDR_IN == i2crs_pkg::CMD_OFS_STATUS)
                             ? {6'h00, nak_reg, busy_reg}
                             : {7'h00, kind_reg};
            end
            case (st_reg)
                MS_IDLE: if (go) begin
                    kind_reg <= WDATA_IN[1];  busy_reg <= 1'b1;
                    nak_reg <= 1'b0;  byte_reg <= 3'h0;
                    st_reg <= MS_START;  phase_reg <= 2'h0;
                end
                MS_START: if (tick) begin
                    // sda falls while scl high
                    phase_reg <= phase_reg + 2'h1;
                    if (phase_reg == 2'h0) begin
                        scl_low_reg <= 1'b0;
                    end else if (phase_reg == 2'h1) begin
                        sda_low_reg <= 1'b1;
                    end else if (phase_reg == 2'h2) begin
                        scl_low_reg <= 1'b1;
                        sh_reg <= frame_byte(byte_reg);  bit_reg <= 4'h0;
                        st_reg <= MS_BIT;  phase_reg <= 2'h0;
                    end
                end
                MS_BIT: if (tick) begin
                    phase_reg <= phase_reg + 2'h1;
                    if (phase_reg == 2'h0) begin
                        // data set while scl low, msb first
                        // ack slot and read byte released
                        sda_low_reg <= (bit_reg == 4'h8 || byte_reg == 3'h3)
                                     ? 1'b0 : ~sh_reg[7];
                    end else if (phase_reg == 2'h1) begin
                        scl_low_reg <= 1'b0;
                    end else if (phase_reg == 2'h2) begin
                        if (bit_reg == 4'h8) begin
                            if (byte_reg != 3'h3) nak_reg <= nak_reg | bus.sda;
                        end else begin
                            sh_reg <= {sh_reg[6:0], bus.sda};
                        end
                    end else begin
                        scl_low_reg <= 1'b1;
                        bit_reg <= bit_reg + 4'h1;
                        if (bit_reg == 4'h8) begin
                            byte_reg <= byte_reg + 3'h1;
                            bit_reg <= 4'h0;
                            sh_reg <= frame_byte(byte_reg + 3'h1);
                            if (kind_reg && byte_reg == 3'h1) begin
                                st_reg <= MS_START;        // restart
                                sda_low_reg <= 1'b0;
                            end else if (byte_reg == (kind_reg ? 3'h3 : 3'h2)
                                         || nak_reg) begin
                                st_reg <= MS_STOP;         // last byte or nak: stop
                                sda_low_reg <= 1'b1;
                            end
                            if (byte_reg == 3'h3) sh_reg <= sh_reg;
                        end
                    end
                end
                MS_STOP: if (tick) begin
                    // sda rises while scl high
                    phase_reg <= phase_reg + 2'h1;
                    if (phase_reg == 2'h0) begin
                        scl_low_reg <= 1'b0;
                    end else if (phase_reg == 2'h1) begin
                        sda_low_reg <= 1'b0;
                        busy_reg <= 1'b0;  st_reg <= MS_IDLE;
                    end
                end
                default: st_reg <= MS_IDLE;
            endcase
        end
    end
    assign bus.scl_oe_m = scl_low_reg;
    assign bus.sda_oe_m = sda_low_reg;
endmodule
`default_nettype wire

// file: testbench/i2crs_checker.sv
// i2crs_checker: timing checks on the two shared wires
// assumes: instanced in the bench beside the joining interface
`timescale 1ns/1ns
`default_nettype none
module i2crs_checker (
    input wire logic REF_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic scl_oe_m,
    input wire logic sda_oe_m,
    input wire logic sda_oe_s,
    input wire logic scl,
    input wire logic sda
);
    // ********************************************************
    // wire timing checks
    // ********************************************************
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // start: data falls while the clock stays high
    sequence start_s; scl && $past(scl) && $fell(sda); endsequence
    // slave must set up well before the clock rises
    sequence low_run_s; !scl [*4]; endsequence
    slave_moves_low_a: assert property ($changed(sda_oe_s) |-> !scl)
        else $error("slave data moved while clock high");
    slave_holds_high_a: assert property (scl && $past(scl) |-> $stable(sda_oe_s))
        else $error("slave made a start or stop");
    ack_setup_a: assert property ($rose(sda_oe_s) |-> low_run_s)
        else $error("slave pull too close to clock rise");
    addr_release_a: assert property (start_s |-> !sda_oe_s [*8])
        else $error("slave drove data during address");
    ack_no_clash_a: assert property (sda_oe_s && scl |-> !sda_oe_m)
        else $error("master drove data during slave bit");
    clock_high_a: assert property ($rose(scl) |-> scl [*8])
        else $error("clock high phase too short");
    clock_low_a: assert property ($fell(scl) |-> !scl [*8])
        else $error("clock low phase too short");
    data_setup_a: assert property ($rose(scl) |-> sda == $past(sda, 2))
        else $error("data not settled before clock rise");
endmodule
`default_nettype wire

// file: testbench/i2c_register_slave_test.sv
// i2c_register_slave_test: both ends joined, driven through command port
// assumes: package, interface and both ends are compiled first
`timescale 1ns/1ns
`default_nettype none
module i2c_register_slave_test;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0, rd = 1'b0, sup = 1'b1, load = 1'b0;
    logic [7:0] fver = 8'h3C;                  // fuse version under test
    logic [7:0] rdata, c0c, c0v, c1v, s, st;
    logic       busy, en;
    int         n_errors = 0, cmp_count = 0;
    i2crs_if bus_if ();
    always #25 clk = ~clk;
    i2crs_slave i_i2crs_slave (.REF_CLK_IN(clk), .RST_N_IN(rst_n),
        .bus(bus_if.slave), .SUPPLY_OK_IN(sup), .FUSE_LOAD_IN(load),
        .FUSE_PART_ID_IN(2'h2), .FUSE_VERSION_IN(fver),
        .FUSE_CONV0_CTRL_IN(8'h05), .FUSE_CONV1_CTRL_IN(8'h0A),
        .FUSE_CONV0_VSET_IN(8'h40), .FUSE_CONV1_VSET_IN(8'h50),
        .BUS_BUSY_OUT(busy), .CONV_ENABLE_OUT(en), .CONV0_CTRL_OUT(c0c),
        .CONV1_CTRL_OUT(), .CONV0_VSET_OUT(c0v), .CONV1_VSET_OUT(c1v));
    i2crs_master i_i2crs_master (.REF_CLK_IN(clk), .RST_N_IN(rst_n),
        .bus(bus_if.master), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
        .RD_IN(rd), .RDATA_OUT(rdata));
    i2crs_checker i_i2crs_checker (.REF_CLK_IN(clk), .RST_N_IN(rst_n),
        .scl_oe_m(bus_if.scl_oe_m), .sda_oe_m(bus_if.sda_oe_m),
        .sda_oe_s(bus_if.sda_oe_s), .scl(bus_if.scl), .sda(bus_if.sda));
    // one strobe cycle; read data is taken in the cycle after it
    task automatic cmd(input logic [1:0] a, input logic [7:0] d, input logic r);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= !r; rd <= r;
        @(posedge clk);
        wr <= 1'b0; rd <= 1'b0;
        #1 s = rdata;
    endtask
    task automatic check(input string nm, input logic [7:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // whole register transfer; polls busy under a bounded count
    task automatic xfer(input logic [7:0] idx, d, input logic r);
        int n;
        n = 0;
        cmd(2'h1, idx, 1'b0); cmd(2'h2, d, 1'b0); cmd(2'h0, {6'h0, r, 1'b1}, 1'b0);
        do begin cmd(2'h3, 8'h00, 1'b1); n++; end while (s[0] !== 1'b0 && n < 3000);
        if (n >= 3000) n_errors++;
        st = s;
        cmd(2'h2, 8'h00, 1'b1);
    endtask
    task automatic test_done();
        if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // watchdog: well beyond the eight transfers below
    initial begin
        #4000000 n_errors++;
        test_done();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk) load <= 1'b1;
        @(posedge clk) load <= 1'b0;
        repeat (4) @(posedge clk);
        check("ctrl0", c0c, 8'h05);
        check("enable", {7'h0, en}, 8'h01);
        xfer(8'h00, 8'h55, 1'b0); // write to read-only place
        xfer(8'h00, 8'h00, 1'b1);
        check("rev", s, {2'h2, i2crs_pkg::REV_RSVD_VALUE});
        xfer(8'h01, 8'h00, 1'b1);
        check("fuse ver", s, fver);
        xfer(8'h06, 8'hA5, 1'b0);
        check("ack", st, 8'h00);
        check("vset0", c0v, 8'hA5);
        xfer(8'h06, 8'h00, 1'b1);
        check("vset0 rd", s, 8'hA5);
        xfer(8'h02, 8'hFF, 1'b0);
        xfer(8'h02, 8'h00, 1'b1);
        check("ctrl0 rsv", s, 8'h0F);
        check("busy", {7'h0, busy}, 8'h00);
        sup <= 1'b0;
        xfer(8'h07, 8'h11, 1'b0);
        check("nak", st & 8'h02, 8'h02);
        check("vset1", c1v, 8'h50);
        test_done();
    end
endmodule
`default_nettype wire
